// [hw/msc_top.sv]
// sideband control of a pluggable module: bus select, reset, low power,
// presence and the attention output, plus the management bus slave front end
// assumes all pin inputs are asynchronous; byte data to and from the
// memory map logic is on mclk
//
// Notes on behaviour
// - with select low, answer management bus commands
// - with select high, ignore all management bus traffic
// - reset held low past least pulse length resets all user settings
// - initialization period starts at the rising edge of the reset pin
// - at reset end, assert attention with not-ready status cleared
// - after power up, post the same completion attention without a reset
// - low-power request high puts the module in reduced power state
// - presence reads low while inserted
// - drive attention low for a fault or a critical status; the code pulls it low only for fault_in or the completion flag
// - answer at 7-bit address 1010000, low bit selects read or write
`timescale 1ns/100ps
`include "msc_consts.svh"

module msc_top #(
	parameter int INIT_CYC = `MSC_INIT_CYC
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       srst,
	// host control pins
	input  wire logic       bus_select_n,
	input  wire logic       module_rst_in_n,
	input  wire logic       low_power_request,
	// management bus pins; sda enable low while driving low
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	// status pins toward the host
	output logic            presence_n,
	output logic            attention_out_n,
	output logic            attention_oe_n,
	// toward the module's own logic
	input  wire logic       fault_in,
	input  wire logic       done_ack,
	output logic            data_not_ready,
	output logic            settings_rst,
	output logic            low_power_mode,
	// byte stream toward the memory map
	output logic            wr_valid,
	output logic [7:0]      wr_byte,
	output logic            wr_is_read,
	input  wire logic [7:0] rd_byte,
	output logic            rd_req
);
	import msc_pkg::*;

	localparam logic [`MSC_CNT_W-1:0] RST_MIN_M1 = `MSC_CNT_W'(`MSC_RST_MIN_CYC - 1);
	localparam logic [`MSC_CNT_W-1:0] INIT_M1    = `MSC_CNT_W'(INIT_CYC - 1);

	msc_state_t q;
	msc_state_t d;
	logic [4:0] pins_s;
	logic       sel_n_s;
	logic       rst_n_s;
	logic       lp_s;
	logic       scl_s;
	logic       sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;

	//--------------------------------------------------------------------
	// pin synchronisers
	//--------------------------------------------------------------------
	// idle levels: select high, reset high, low power low, scl and sda high
	msc_pin_sync #(
		.WIDTH   (5),
		.RST_VAL (32'h0000_001B)
	) u_sync (
		.mclk     (mclk),
		.srst     (srst),
		.pin_in   ({bus_select_n, module_rst_in_n, low_power_request, scl_in, sda_in}),
		.pin_sync (pins_s)
	);

	assign sel_n_s = pins_s[4];
	assign rst_n_s = pins_s[3];
	assign lp_s    = pins_s[2];
	assign scl_s   = pins_s[1];
	assign sda_s   = pins_s[0];

	// bus conditions seen on the synchronised lines
	assign scl_rise  = scl_s & ~q.scl_prev;
	assign scl_fall  = ~scl_s & q.scl_prev;
	assign bus_start = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
	assign bus_stop  = scl_s & q.scl_prev & ~q.sda_prev & sda_s;

	//--------------------------------------------------------------------
	// next state
	//--------------------------------------------------------------------
	always_comb begin
		d          = q;
		d.wr_valid = 1'b0;
		d.rd_req   = 1'b0;
		d.scl_prev = scl_s;
		d.sda_prev = sda_s;
		d.lp_mode  = lp_s;

		// reset sequencing
		unique case (q.rst_st)
			RS_RUN: begin
				if (!rst_n_s) begin
					d.rst_st = RS_LOW;
					d.cnt    = '0;
				end
			end
			RS_LOW: begin
				if (rst_n_s) begin
					d.rst_st = RS_RUN;
				end else if (q.cnt == RST_MIN_M1) begin
					d.rst_st       = RS_HELD;
					d.settings_rst = 1'b1;
					d.not_ready    = 1'b1;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
			RS_HELD: begin
				if (rst_n_s) begin
					d.rst_st = RS_INIT;
					d.cnt    = '0;
				end
			end
			RS_INIT: begin
				// a new low level during init restarts the qualification
				if (!rst_n_s) begin
					d.rst_st = RS_LOW;
					d.cnt    = '0;
				end else if (q.cnt == INIT_M1) begin
					d.rst_st       = RS_RUN;
					d.settings_rst = 1'b0;
					d.not_ready    = 1'b0;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
		endcase

		// completion flag: the set is applied after the clear so it wins
		if (done_ack) begin
			d.done_flag = 1'b0;
		end
		if (q.rst_st == RS_INIT && rst_n_s && q.cnt == INIT_M1) begin
			d.done_flag = 1'b1;
		end
		d.attn_n = ~(q.done_flag | fault_in);

		// management bus slave
		if (sel_n_s) begin
			// deselected: drop any transfer and leave the line alone
			d.bus_st    = BS_IDLE;
			d.sda_drive = 1'b0;
		end else if (bus_start) begin
			d.bus_st    = BS_ADDR;
			d.bit_cnt   = 3'h0;
			d.sda_drive = 1'b0;
		end else if (bus_stop) begin
			d.bus_st    = BS_IDLE;
			d.sda_drive = 1'b0;
		end else begin
			unique case (q.bus_st)
				BS_IDLE: begin
					d.sda_drive = 1'b0;
				end
				BS_ADDR, BS_WDATA: begin
					if (scl_rise) begin
						d.shreg   = {q.shreg[6:0], sda_s};
						d.bit_cnt = q.bit_cnt + 1'b1;
						if (q.bit_cnt == 3'h7) begin
							d.bus_st = (q.bus_st == BS_ADDR) ? BS_AACK : BS_WACK;
						end
					end
				end
				BS_AACK: begin
					if (scl_fall && !q.sda_drive) begin
						if (q.shreg[7:1] == `MSC_DEV_ADDR) begin
							d.sda_drive = 1'b1;
							d.rw        = q.shreg[0];
						end else begin
							d.bus_st = BS_IDLE; // another device's address
						end
					end else if (scl_fall) begin
						d.bit_cnt = 3'h0;
						if (q.rw) begin
							d.bus_st    = BS_RDATA;
							d.shreg     = rd_byte;
							d.sda_drive = ~rd_byte[7];
							d.rd_req    = 1'b1;
						end else begin
							d.bus_st    = BS_WDATA;
							d.sda_drive = 1'b0;
						end
					end
				end
				BS_WACK: begin
					if (scl_fall && !q.sda_drive) begin
						d.sda_drive = 1'b1;
						d.wr_valid  = 1'b1;
						d.wr_byte   = q.shreg;
					end else if (scl_fall) begin
						d.sda_drive = 1'b0;
						d.bit_cnt   = 3'h0;
						d.bus_st    = BS_WDATA;
					end
				end
				BS_RDATA: begin
					if (scl_fall && q.bit_cnt == 3'h7) begin
						d.sda_drive = 1'b0;
						d.bus_st    = BS_RACK;
					end else if (scl_fall) begin
						d.bit_cnt   = q.bit_cnt + 1'b1;
						d.shreg     = {q.shreg[6:0], 1'b0};
						d.sda_drive = ~q.shreg[6];
					end
				end
				BS_RACK: begin
					// host not-acknowledge ends the read
					if (scl_rise && sda_s) begin
						d.bus_st = BS_IDLE;
					end else if (scl_fall) begin
						d.bus_st    = BS_RDATA;
						d.bit_cnt   = 3'h0;
						d.shreg     = rd_byte;
						d.sda_drive = ~rd_byte[7];
						d.rd_req    = 1'b1;
					end
				end
				default: begin
					d.bus_st    = BS_IDLE;
					d.sda_drive = 1'b0;
				end
			endcase
		end
	end

	//--------------------------------------------------------------------
	// state register
	//--------------------------------------------------------------------
	// power up enters the init period directly, so completion is posted
	always_ff @(posedge mclk) begin
		if (srst) begin
			q              <= '0;
			q.rst_st       <= RS_INIT;
			q.not_ready    <= 1'b1;
			q.settings_rst <= 1'b1;
			q.scl_prev     <= 1'b1;
			q.sda_prev     <= 1'b1;
			q.attn_n       <= 1'b1;
			q.bus_st       <= BS_IDLE;
		end else begin
			q <= d;
		end
	end

	//--------------------------------------------------------------------
	// outputs
	//--------------------------------------------------------------------
	assign sda_out         = 1'b0;
	assign sda_oe_n        = ~q.sda_drive;
	assign presence_n      = 1'b0;
	assign attention_out_n = q.attn_n;
	assign attention_oe_n  = q.attn_n; // open drain: only pulls low
	assign data_not_ready  = q.not_ready;
	assign settings_rst    = q.settings_rst;
	assign low_power_mode  = q.lp_mode;
	assign wr_valid        = q.wr_valid;
	assign wr_byte         = q.wr_byte;
	assign wr_is_read      = q.rw;
	assign rd_req          = q.rd_req;

endmodule : msc_top

// [hw/msc_consts.svh]
// constants for the module sideband control block
// assumes a 20 MHz mclk; times are in ns, counts derived from them
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

// clock period of mclk
`define MSC_CLK_NS        50
// 7-bit management bus address, low bit of the address byte is read/write
`define MSC_DEV_ADDR      7'h50
// least low time on the reset pin that counts as a real reset
`define MSC_RST_MIN_NS    10000
`define MSC_RST_MIN_CYC   ((`MSC_RST_MIN_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS)
// initialization period after reset release or power up (longest time)
`define MSC_INIT_NS       2000000
`define MSC_INIT_CYC      (`MSC_INIT_NS / `MSC_CLK_NS)
// width of the shared cycle counter
`define MSC_CNT_W         16

`endif

// [hw/msc_pkg.sv]
// types for the module sideband control block
// assumes msc_consts.svh is on the include path
`include "msc_consts.svh"

package msc_pkg;

	// reset sequencing states
	typedef enum logic [1:0] {
		RS_RUN  = 2'b00,
		RS_LOW  = 2'b01,
		RS_HELD = 2'b10,
		RS_INIT = 2'b11
	} msc_rst_st_t;

	// management bus slave states
	typedef enum logic [2:0] {
		BS_IDLE  = 3'b000,
		BS_ADDR  = 3'b001,
		BS_AACK  = 3'b010,
		BS_WDATA = 3'b011,
		BS_WACK  = 3'b100,
		BS_RDATA = 3'b101,
		BS_RACK  = 3'b110
	} msc_bus_st_t;

	// whole state of the top module
	typedef struct packed {
		msc_rst_st_t             rst_st;
		logic [`MSC_CNT_W-1:0]   cnt;
		msc_bus_st_t             bus_st;
		logic [2:0]              bit_cnt;
		logic [7:0]              shreg;
		logic                    rw;
		logic                    sda_drive;
		logic                    scl_prev;
		logic                    sda_prev;
		logic                    not_ready;
		logic                    done_flag;
		logic                    settings_rst;
		logic                    lp_mode;
		logic                    attn_n;
		logic                    wr_valid;
		logic [7:0]              wr_byte;
		logic                    rd_req;
	} msc_state_t;

endpackage : msc_pkg

// [hw/msc_pin_sync.sv]
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to mclk; first stage feeds only the second
`timescale 1ns/100ps

module msc_pin_sync #(
	parameter int          WIDTH    = 1,
	parameter logic [31:0] RST_VAL  = 32'h0000_0000
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             srst,
	// pins in, synchronised levels out
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} msc_sync_state_t;

	msc_sync_state_t q;
	msc_sync_state_t d;

	// shift the pin through both stages
	always_comb begin
		d    = q;
		d.s1 = pin_in;
		d.s2 = q.s1;
	end

	// reset to the pin's idle level so no false edge appears at release
	always_ff @(posedge mclk) begin
		if (srst) begin
			q.s1 <= RST_VAL[WIDTH-1:0];
			q.s2 <= RST_VAL[WIDTH-1:0];
		end else begin
			q <= d;
		end
	end

	assign pin_sync = q.s2;

endmodule : msc_pin_sync

// [verification/msc_props.sv]
// checker of the sideband control outputs
// assumes it is bound into msc_top; INIT_CYC is handed on by the bind
`timescale 1ns/100ps
`include "msc_consts.svh"

module msc_props #(
	parameter int INIT_CYC = 50
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// host pins and local inputs
	input wire logic bus_select_n,
	input wire logic module_rst_in_n,
	input wire logic low_power_request,
	input wire logic fault_in,
	// outputs watched
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic presence_n,
	input wire logic attention_out_n,
	input wire logic attention_oe_n,
	input wire logic data_not_ready,
	input wire logic settings_rst,
	input wire logic low_power_mode
);
	localparam int RST_MIN = `MSC_RST_MIN_CYC;
	logic [7:0] low_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// low time of the reset pin; saturates so a long hold cannot wrap
	always_ff @(posedge mclk)
		low_q <= (srst || module_rst_in_n) ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
	a_presence_low: assert property (presence_n == 1'b0)
		else $error("presence not low");
	a_sda_only_low: assert property (!sda_oe_n |-> !sda_out)
		else $error("sda driven high");
	a_attn_oe_same: assert property (attention_oe_n == attention_out_n)
		else $error("attention enable differs");
	a_attn_on_fault: assert property (fault_in |=> !attention_out_n)
		else $error("fault not reported");
	a_select_quiet: assert property (bus_select_n [*5] |-> sda_oe_n)
		else $error("sda driven while deselected");
	a_lp_follow: assert property ($stable(low_power_request) [*5] |->
		low_power_mode == low_power_request)
		else $error("low power not followed");
	a_short_ignored: assert property ($rose(settings_rst) |-> low_q >= 8'(RST_MIN))
		else $error("reset on short pulse");
	a_long_resets: assert property (low_q == 8'(RST_MIN + 4) |->
		settings_rst && data_not_ready)
		else $error("long pulse ignored");
	a_init_from_rise: assert property ($rose(module_rst_in_n) && settings_rst |->
		(settings_rst throughout ##INIT_CYC 1'b1) ##[1:6] !settings_rst)
		else $error("init period misplaced");
	a_done_attn: assert property ($fell(data_not_ready) |-> ##[0:2] !attention_out_n)
		else $error("no completion attention");
	c_done: cover property ($fell(data_not_ready));
	c_ack: cover property ($fell(sda_oe_n));
	c_pin_rst: cover property ($rose(settings_rst));
endmodule : msc_props

bind msc_top msc_props #(.INIT_CYC(INIT_CYC)) u_props (.mclk, .srst, .bus_select_n,
	.module_rst_in_n, .low_power_request, .fault_in, .sda_out, .sda_oe_n, .presence_n,
	.attention_out_n, .attention_oe_n, .data_not_ready, .settings_rst, .low_power_mode);

// [verification/msc_host_model.sv]
// host board model: master on the shared 2-wire bus
// assumes pulled-up lines; the bench resolves SDA from all enables
`timescale 1ns/100ps

module msc_host_model (
	// clock
	input wire logic mclk,
	// bus; sda_drv high means released
	output logic     scl,
	output logic     sda_drv,
	input wire logic sda_line
);
	// idle bus stands still, both lines released
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic hw(input int n);
		repeat (n) @(posedge mclk);
	endtask : hw
	// one bit slot; 16 mclk cycles, twice what the slave needs
	task automatic slot(input logic b, output logic seen);
		hw(4);
		sda_drv <= b;
		hw(4);
		scl <= 1'b1;
		hw(8);
		seen = sda_line;
		scl <= 1'b0;
	endtask : slot
	// start, address byte, data byte, stop; acks returned active high
	task automatic frame(input logic [7:0] ab, input logic [7:0] db,
		output logic a_ack, output logic d_ack);
		logic s;
		hw(4);
		sda_drv <= 1'b0;
		hw(8);
		scl <= 1'b0;
		for (int i = 7; i >= 0; i--) slot(ab[i], s);
		slot(1'b1, s);
		a_ack = ~s;
		for (int i = 7; i >= 0; i--) slot(db[i], s);
		slot(1'b1, s);
		d_ack = ~s;
		hw(4);
		sda_drv <= 1'b0;
		hw(4);
		scl <= 1'b1;
		hw(8);
		sda_drv <= 1'b1;
	endtask : frame
	// start, address byte, one byte read back, not-acknowledge, stop
	task automatic read_frame(input logic [7:0] ab, output logic a_ack,
		output logic [7:0] rb);
		logic s;
		hw(4);
		sda_drv <= 1'b0;
		hw(8);
		scl <= 1'b0;
		for (int i = 7; i >= 0; i--) slot(ab[i], s);
		slot(1'b1, s);
		a_ack = ~s;
		// line left released so the slave alone sets each bit
		for (int i = 7; i >= 0; i--) slot(1'b1, rb[i]);
		slot(1'b1, s);
		hw(4);
		sda_drv <= 1'b0;
		hw(4);
		scl <= 1'b1;
		hw(8);
		sda_drv <= 1'b1;
	endtask : read_frame
endmodule : msc_host_model

// [verification/tb.sv]
// bench of msc_top: power up, faults, low power, pin reset, bus writes and a read
// assumes msc_host_model on the bus and a pull-up on SDA
`timescale 1ns/100ps
`include "msc_consts.svh"
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("MISMATCH %0t %s", $time, m); end end

module tb;
	import msc_pkg::*;
	localparam int INIT = 50;
	localparam int RST_MIN = `MSC_RST_MIN_CYC;
	int n_fail = 0, n_checks = 0, n_wr = 0, w0, n_rd = 0, r0;
	logic mclk = 1'b0, srst = 1'b1, bus_select_n = 1'b1, module_rst_in_n = 1'b1;
	logic low_power_request = 1'b0, fault_in = 1'b0, done_ack = 1'b0;
	logic [7:0] rd_byte = 8'h00, wr_byte, got_q, ab, db, rb;
	logic scl, sda_drv, sda_line, sda_out, sda_oe_n, presence_n, attention_out_n;
	logic attention_oe_n, data_not_ready, settings_rst, low_power_mode;
	logic wr_valid, wr_is_read, rd_req, aa, da, e;
	// wired-and with pull-up: released means high
	assign sda_line = sda_drv & (sda_oe_n | sda_out);
	always #25 mclk = ~mclk;
	msc_top #(.INIT_CYC(INIT)) uut (.mclk, .srst, .bus_select_n, .module_rst_in_n,
		.low_power_request, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe_n,
		.presence_n, .attention_out_n, .attention_oe_n, .fault_in, .done_ack,
		.data_not_ready, .settings_rst, .low_power_mode, .wr_valid, .wr_byte,
		.wr_is_read, .rd_byte, .rd_req);
	msc_host_model host (.mclk, .scl, .sda_drv, .sda_line);
	// keep the latest byte handed to the memory map and count them
	always @(posedge mclk) begin
		if (wr_valid === 1'b1) begin
			got_q <= wr_byte;
			n_wr <= n_wr + 1;
		end
		if (rd_req === 1'b1) begin
			n_rd <= n_rd + 1;
		end
	end
	function automatic logic exp_ack(input logic sel_n, input logic [7:0] a);
		return !sel_n && a[7:1] == `MSC_DEV_ADDR;
	endfunction : exp_ack
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	task automatic print_verdict();
		if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	// status is left alone until completion shows, then acknowledged
	task automatic wait_done(input int lim);
		for (int i = 0; i < lim && attention_out_n !== 1'b0; i++) cyc(1);
		`CHK(attention_out_n, 1'b0, "no completion")
		`CHK(data_not_ready, 1'b0, "still not ready")
		`CHK(settings_rst, 1'b0, "settings held")
		done_ack <= 1'b1;
		cyc(1);
		done_ack <= 1'b0;
		cyc(3);
		`CHK(attention_out_n, 1'b1, "attention stuck")
	endtask : wait_done
	task automatic pin_reset(input int n);
		module_rst_in_n <= 1'b0;
		cyc(n);
		module_rst_in_n <= 1'b1;
		cyc(6);
	endtask : pin_reset
	initial begin
		void'($urandom(32'h5a941c82));
		rd_byte <= 8'($urandom);
		cyc(8);
		srst <= 1'b0;
		cyc(2);
		`CHK(settings_rst, 1'b1, "no power-up default")
		`CHK(presence_n, 1'b0, "presence high")
		wait_done(INIT + 20);
		fault_in <= 1'b1;
		cyc(3);
		`CHK(attention_out_n, 1'b0, "fault unseen")
		fault_in <= 1'b0;
		cyc(3);
		`CHK(attention_out_n, 1'b1, "attention held")
		for (int i = 0; i < 6; i++) begin
			low_power_request <= 1'($urandom);
			cyc(5);
			`CHK(low_power_mode, low_power_request, "low power")
		end
		// glitch just under the least length, then a real reset
		pin_reset(RST_MIN - 2);
		`CHK(settings_rst, 1'b0, "short pulse reset")
		pin_reset(RST_MIN + 40);
		`CHK(settings_rst, 1'b1, "long pulse ignored")
		cyc(INIT - 12);
		`CHK(data_not_ready, 1'b1, "init began early")
		wait_done(30);
		// matched, neighbour address, deselected, a read, then random frames
		for (int i = 0; i < 8; i++) begin
			bus_select_n <= (i == 2) ? 1'b1 : (i > 3) ? 1'($urandom) : 1'b0;
			ab = {7'(`MSC_DEV_ADDR), 1'b0};
			if (i == 1) ab[1] = ~ab[1];
			if (i > 3 && $urandom % 2) ab[7:1] = 7'($urandom);
			if (i == 3) ab[0] = 1'b1;
			db = 8'($urandom);
			cyc(4);
			w0 = n_wr;
			r0 = n_rd;
			e = exp_ack(bus_select_n, ab);
			if (ab[0]) host.read_frame(ab, aa, rb);
			else host.frame(ab, db, aa, da);
			cyc(4);
			`CHK(aa, e, "address ack")
			if (ab[0]) begin
				`CHK(rb, rd_byte, "read byte")
				`CHK(n_rd - r0, 1, "read requests")
				`CHK(wr_is_read, 1'b1, "read direction")
			end else begin
				`CHK(da, e, "data ack")
				`CHK(n_wr - w0, e ? 1 : 0, "byte count")
				if (e) `CHK(got_q, db, "byte value")
				if (e) `CHK(wr_is_read, 1'b0, "direction")
			end
		end
		print_verdict();
	end
	// hang guard, well beyond the few thousand cycles the run needs
	initial begin
		cyc(30000);
		n_fail++;
		print_verdict();
	end
endmodule : tb
